// ==== pkg/usfe_regs.vh ====
// Purpose: constants for the setup field and event flag block
// Assumes: byte-addressed register port, 100 MHz clock
// Notes:   offsets are byte addresses, one aligned word each
`ifndef USFE_REGS_VH
`define USFE_REGS_VH
`define USFE_ADDR_W         8
`define USFE_OFF_INDEX      8'h00
`define USFE_OFF_LENGTH     8'h04
`define USFE_OFF_EVENT      8'h08
`define USFE_OFF_NAK_FLAGS  8'h0c
`define USFE_OFF_NAK_MASK   8'h10
`define USFE_OFF_DONE_FLAGS 8'h14
`define USFE_OFF_DONE_MASK  8'h18
`define USFE_OFF_ZERO_FLAGS 8'h1c
`define USFE_OFF_CONFIG     8'h20
`define USFE_BIT_SETUP      0
`define USFE_BIT_STAT_TOK   1
`define USFE_BIT_STAT_DONE  2
`define USFE_BIT_ZERO_LEN   3
`define USFE_BIT_SOF        4
`define USFE_BIT_CTRL_DONE  5
`define USFE_BIT_EP_DONE    6
`define USFE_BIT_NAK        7
`define USFE_MASK_LSB       8
`define USFE_BIT_CREATE_SOF 0
`define USFE_RESET_EVENT    16'h0000
`define USFE_RESET_FLAGS    8'h00
`define USFE_RESET_MASKS    8'h00
`define USFE_FRAME_TIME_NS  1000000
`define USFE_CLK_PERIOD_NS  10
`define USFE_FRAME_CYCLES   (`USFE_FRAME_TIME_NS / `USFE_CLK_PERIOD_NS)
`endif

// ==== rtl/usfe_flag_bank.v ====
// Purpose: bank of per-endpoint sticky flags with a gate mask
// Assumes: endpoint 0 takes no part, flag bit 0 reads as zero
// Notes:   set wins over clear in the same cycle
`default_nettype none
module usfe_flag_bank #(
  parameter WIDTH = 8
) (
  input  wire             clock_in,
  input  wire             reset_in,
  input  wire [WIDTH-1:0] set_in,
  input  wire             clear_all_in,
  input  wire             mask_we_in,
  input  wire [WIDTH-1:0] mask_wdata_in,
  output reg  [WIDTH-1:0] flags_out,
  output reg  [WIDTH-1:0] mask_out,
  output wire             any_out
);
  wire [WIDTH-1:0] next_flags;

  // the summary needs one enabled flag; a 1 in the mask enables the endpoint
  assign any_out = |(flags_out & mask_out);

  // each flag is sticky; a fresh event beats a clear arriving alongside it
  genvar i;
  generate
    for (i = 1; i < WIDTH; i = i + 1)
    begin : g_flag
      assign next_flags[i] = set_in[i] | (~clear_all_in & flags_out[i]);
    end
  endgenerate

  // endpoint 0 never contributes
  assign next_flags[0] = 1'b0;

  // one process owns the whole flag vector, so each bit has a single driver
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
      flags_out <= {WIDTH{1'b0}};
    else
      flags_out <= next_flags;
  end

  // mask register, enables all endpoints after reset is a software job
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
      mask_out <= {WIDTH{1'b0}};
    else if (mask_we_in)
      mask_out <= mask_wdata_in;
  end
endmodule
`default_nettype wire

// ==== rtl/usfe_top.v ====
// Purpose: setup index/length words and the main event flag register
// Assumes: link events arrive as one-cycle pulses synchronous to clock_in
// Notes:   one level interrupt covers all unmasked event flags
`include "usfe_regs.vh"
`default_nettype none
// How it works
// - index word holds setup bytes five, six
// - length word holds setup bytes seven, eight
// - mask one blocks flag from its pin
// - nak from nonzero endpoint sets nak flag
// - per-endpoint mask selects nak contributors
// - writing one to nak flag clears bank
// - nonzero endpoint transfer done sets flag
// - writing one clears per-endpoint done bank
// - endpoint zero transfer done sets flag
// - counted frame in create-sof mode, else sof token, sets flag
// - zero-length packet received sets flag
// - control-read status zero packet sets nothing
// - writing one clears per-endpoint zero bank unless zero-length packet received same cycle
// - setup token on endpoint zero sets flag
// - status stage done sets status-done flag
// - status packet in control read sets flag
module usfe_top #(
  parameter EP_COUNT     = 8,
  parameter FRAME_CYCLES = `USFE_FRAME_CYCLES
) (
  input  wire                   clock_in,
  input  wire                   reset_in,
  input  wire [`USFE_ADDR_W-1:0] addr_in,
  input  wire [31:0]            wdata_in,
  input  wire                   write_in,
  input  wire                   read_in,
  output reg  [31:0]            rdata_out,
  input  wire                   setup_byte_valid_in,
  input  wire [2:0]             setup_byte_num_in,
  input  wire [7:0]             setup_byte_in,
  input  wire                   setup_token_in,
  input  wire                   status_token_in,
  input  wire                   status_done_in,
  input  wire                   ctrl_done_in,
  input  wire                   sof_token_in,
  input  wire                   zero_len_rx_in,
  input  wire                   zero_len_status_rd_in,
  input  wire [EP_COUNT-1:0]    ep_nak_in,
  input  wire [EP_COUNT-1:0]    ep_done_in,
  input  wire [EP_COUNT-1:0]    ep_zero_len_in,
  output wire [7:0]             event_pins_out,
  output wire                   irq_out
);
  reg  [15:0]         index_word;
  reg  [15:0]         length_word;
  reg  [7:0]          event_flag;
  reg  [7:0]          event_mask;
  reg                 create_sof;
  reg  [31:0]         frame_count;
  reg  [7:0]          next_event_flag;
  reg  [7:0]          ev_set;
  reg  [EP_COUNT-1:0] zero_flags;
  reg  [31:0]         next_rdata;
  wire [EP_COUNT-1:0] nak_flags;
  wire [EP_COUNT-1:0] nak_mask;
  wire [EP_COUNT-1:0] done_flags;
  wire [EP_COUNT-1:0] done_mask;
  wire                nak_any;
  wire                done_any;
  wire                frame_tick;
  wire                wr_event;
  wire [EP_COUNT-1:0] ep_nz;

  // address match used by every write path
  function hit;
    input [`USFE_ADDR_W-1:0] a;
    input [`USFE_ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  assign wr_event = write_in & hit(addr_in, `USFE_OFF_EVENT);
  assign ep_nz    = {{(EP_COUNT-1){1'b1}}, 1'b0};

  // capture setup bytes 5..8 as they stream in; earlier bytes belong elsewhere
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      index_word  <= 16'h0000;
      length_word <= 16'h0000;
    end
    else if (setup_byte_valid_in)
    begin
      case (setup_byte_num_in)
        3'h4: index_word[7:0]   <= setup_byte_in;
        3'h5: index_word[15:8]  <= setup_byte_in;
        3'h6: length_word[7:0]  <= setup_byte_in;
        3'h7: length_word[15:8] <= setup_byte_in;
        default: ;
      endcase
    end
  end

  // per-endpoint banks; the summary write-one clears a whole bank
  usfe_flag_bank #(.WIDTH(EP_COUNT)) u_nak (
    .clock_in      (clock_in),
    .reset_in      (reset_in),
    .set_in        (ep_nak_in & ep_nz),
    .clear_all_in  (wr_event & wdata_in[`USFE_BIT_NAK]),
    .mask_we_in    (write_in & hit(addr_in, `USFE_OFF_NAK_MASK)),
    .mask_wdata_in (wdata_in[EP_COUNT-1:0]),
    .flags_out     (nak_flags),
    .mask_out      (nak_mask),
    .any_out       (nak_any)
  );

  usfe_flag_bank #(.WIDTH(EP_COUNT)) u_done (
    .clock_in      (clock_in),
    .reset_in      (reset_in),
    .set_in        (ep_done_in & ep_nz),
    .clear_all_in  (wr_event & wdata_in[`USFE_BIT_EP_DONE]),
    .mask_we_in    (write_in & hit(addr_in, `USFE_OFF_DONE_MASK)),
    .mask_wdata_in (wdata_in[EP_COUNT-1:0]),
    .flags_out     (done_flags),
    .mask_out      (done_mask),
    .any_out       (done_any)
  );

  // zero-length bank: status-stage packets of control reads are excluded
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
      zero_flags <= {EP_COUNT{1'b0}};
    else
      zero_flags <= (zero_len_status_rd_in ? zero_flags : (zero_flags | ep_zero_len_in))
                    & ~((wr_event & wdata_in[`USFE_BIT_ZERO_LEN] &
                         ~(zero_len_rx_in & ~zero_len_status_rd_in))
                        ? {EP_COUNT{1'b1}} : {EP_COUNT{1'b0}});
  end

  // self-generated frame timer; only runs in create-sof mode
  assign frame_tick = create_sof && (frame_count == FRAME_CYCLES - 1);
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
      frame_count <= 32'h00000000;
    else if (!create_sof || frame_tick)
      frame_count <= 32'h00000000;
    else
      frame_count <= frame_count + 32'h00000001;
  end

  // config register: frame mode select
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
      create_sof <= 1'b0;
    else if (write_in && hit(addr_in, `USFE_OFF_CONFIG))
      create_sof <= wdata_in[`USFE_BIT_CREATE_SOF];
  end

  // event set terms gathered in bit order
  always @*
  begin
    ev_set = 8'h00;
    ev_set[`USFE_BIT_SETUP]     = setup_token_in;
    ev_set[`USFE_BIT_STAT_TOK]  = status_token_in;
    ev_set[`USFE_BIT_STAT_DONE] = status_done_in;
    ev_set[`USFE_BIT_ZERO_LEN]  = zero_len_rx_in & ~zero_len_status_rd_in;
    ev_set[`USFE_BIT_SOF]       = create_sof ? frame_tick : sof_token_in;
    ev_set[`USFE_BIT_CTRL_DONE] = ctrl_done_in;
    // a bank being cleared this cycle must not re-arm its summary
    ev_set[`USFE_BIT_EP_DONE]   = |(ep_done_in & ep_nz)
                                  | (done_any & ~(wr_event & wdata_in[`USFE_BIT_EP_DONE]));
    ev_set[`USFE_BIT_NAK]       = |(ep_nak_in & ep_nz & nak_mask)
                                  | (nak_any & ~(wr_event & wdata_in[`USFE_BIT_NAK]));
  end

  // write-one clears each flag, but a same-cycle event keeps it set;
  // the summaries re-arm while any enabled bank bit is still standing
  always @*
  begin
    next_event_flag = event_flag;
    if (wr_event)
      next_event_flag = event_flag & ~wdata_in[7:0];
    next_event_flag = next_event_flag | ev_set;
  end

  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      event_flag <= `USFE_RESET_FLAGS;
      event_mask <= `USFE_RESET_MASKS;
    end
    else
    begin
      event_flag <= next_event_flag;
      if (wr_event)
        event_mask <= wdata_in[15:8]; // upper half ignores writes
    end
  end

  // pins: flag drives its pin only while its mask bit is clear
  assign event_pins_out = event_flag & ~event_mask;
  assign irq_out        = |event_pins_out;

  // read mux; upper half reads zero, unmapped addresses read zero
  always @*
  begin
    next_rdata = 32'h00000000;
    case (addr_in)
      `USFE_OFF_INDEX:      next_rdata = {16'h0000, index_word};
      `USFE_OFF_LENGTH:     next_rdata = {16'h0000, length_word};
      `USFE_OFF_EVENT:      next_rdata = {16'h0000, event_mask, event_flag};
      `USFE_OFF_NAK_FLAGS:  next_rdata[EP_COUNT-1:0] = nak_flags;
      `USFE_OFF_NAK_MASK:   next_rdata[EP_COUNT-1:0] = nak_mask;
      `USFE_OFF_DONE_FLAGS: next_rdata[EP_COUNT-1:0] = done_flags;
      `USFE_OFF_DONE_MASK:  next_rdata[EP_COUNT-1:0] = done_mask;
      `USFE_OFF_ZERO_FLAGS: next_rdata[EP_COUNT-1:0] = zero_flags;
      `USFE_OFF_CONFIG:     next_rdata[0] = create_sof;
      default:              next_rdata = 32'h00000000;
    endcase
  end

  // read data registered, valid only the cycle after the strobe
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
      rdata_out <= 32'h00000000;
    else if (read_in)
      rdata_out <= next_rdata;
    else
      rdata_out <= 32'h00000000;
  end
endmodule
`default_nettype wire

// ==== verif/usb_setup_fields_and_event_flags_bench.sv ====
// Purpose: self-checking bench for setup words and event flags
// Assumes: host model sends the packet, bench the link events
// Notes:   frame count cut to 20 cycles to keep the run short
`default_nettype none
module usb_setup_fields_and_event_flags_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_in, reset_in, write_in, read_in, go, irq_out;
  logic [7:0]  addr_in, setup_byte_in, event_pins_out;
  logic [31:0] wdata_in, rdata_out;
  logic [63:0] pkt = 64'h8877665544332211;
  logic        setup_byte_valid_in, setup_token_in, status_token_in, status_done_in;
  logic        ctrl_done_in, sof_token_in, zero_len_rx_in, zero_len_status_rd_in;
  logic [2:0]  setup_byte_num_in;
  logic [7:0]  ep_nak_in, ep_done_in, ep_zero_len_in;
  logic [5:0]  ev = 6'h00;
  logic [23:0] epv = 24'h0;
  int          err_total = 0, n_tests = 0, cyc = 0;
  assign {zero_len_status_rd_in, ctrl_done_in, sof_token_in, zero_len_rx_in,
          status_done_in, status_token_in} = ev;
  assign {ep_nak_in, ep_done_in, ep_zero_len_in} = epv;
  usfe_top #(.EP_COUNT(8), .FRAME_CYCLES(20)) uut (.*);
  usfe_host_model host (.clock_in(clock_in), .go_in(go), .pkt_in(pkt),
    .valid_out(setup_byte_valid_in), .num_out(setup_byte_num_in),
    .byte_out(setup_byte_in), .token_out(setup_token_in));
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // a hang ends the run here rather than stalling it
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    write_in <= 1'b1;
    @(posedge clock_in);
    write_in <= 1'b0;
    @(posedge clock_in);
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge clock_in);
    read_in <= 1'b0;
    #1 chk(rdata_out, exp);
    @(posedge clock_in);
  endtask
  task automatic pulse(input logic [5:0] e, input logic [23:0] p);
    ev <= e;
    epv <= p;
    @(posedge clock_in);
    ev <= 6'h00;
    epv <= 24'h0;
    @(posedge clock_in);
  endtask
  task automatic final_report();
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    {reset_in, write_in, read_in, go} = 4'h8;
    addr_in = 8'h00;
    wdata_in = 32'h0;
    repeat (12) @(posedge clock_in);
    reset_in <= 1'b0;
    @(posedge clock_in);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'hfc, 32'h0);
    go <= 1'b1;
    @(posedge clock_in);
    go <= 1'b0;
    repeat (10) @(posedge clock_in);
    wr(8'h00, 32'hffff);
    rd(8'h00, {16'h0, pkt[47:32]});
    rd(8'h04, {16'h0, pkt[63:48]});
    rd(8'h08, 32'h1);
    wr(8'h08, 32'h1);
    $display("setup words done");
    for (int k = 0; k < 5; k++)
    begin
      pulse(6'h01 << k, 24'h0);
      chk(event_pins_out, 8'h02 << k);
      wr(8'h08, 32'h02 << k);
      chk(irq_out, 1'b0);
    end
    wr(8'h08, 32'hff00);
    pulse(6'h1f, 24'h0);
    chk(event_pins_out, 8'h00);
    rd(8'h08, 32'hff3e);
    wr(8'h08, 32'h3e);
    pulse(6'h24, 24'h0);
    rd(8'h08, 32'h0);
    $display("event flags done");
    wr(8'h10, 32'hfe);
    pulse(6'h00, 24'h040000);
    rd(8'h0c, 32'h04);
    rd(8'h08, 32'h80);
    wr(8'h08, 32'h80);
    rd(8'h0c, 32'h0);
    rd(8'h08, 32'h0);
    wr(8'h08, 32'h80);
    wr(8'h10, 32'h0);
    pulse(6'h00, 24'h080100);
    rd(8'h08, 32'h0);
    pulse(6'h00, 24'h000200);
    rd(8'h14, 32'h02);
    rd(8'h08, 32'h40);
    wr(8'h08, 32'h40);
    rd(8'h14, 32'h0);
    pulse(6'h00, 24'h000008);
    rd(8'h1c, 32'h08);
    wr(8'h08, 32'h08);
    rd(8'h1c, 32'h0);
    $display("endpoint banks done");
    wr(8'h08, 32'hff);
    wr(8'h20, 32'h1);
    repeat (22) @(posedge clock_in);
    chk(event_pins_out[4], 1'b1);
    $display("frame count done");
    final_report();
  end
endmodule
`default_nettype wire

// ==== verif/usfe_host_model.sv ====
// Purpose: host side that sends one setup packet
// Assumes: one byte a clock, first byte first, token with the last byte
// Notes:   idle byte lines toggle so stale data is never trusted
`default_nettype none
module usfe_host_model (
  input  wire logic        clock_in,
  input  wire logic        go_in,
  input  wire logic [63:0] pkt_in,
  output var  logic        valid_out = 1'b0,
  output var  logic [2:0]  num_out = 3'h0,
  output var  logic [7:0]  byte_out = 8'h00,
  output var  logic        token_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt = 4'h8;
  // walk the eight bytes, then stop
  always @(posedge clock_in)
  begin
    valid_out <= !cnt[3];
    num_out <= cnt[2:0];
    byte_out <= cnt[3] ? ~byte_out : pkt_in[cnt[2:0]*8 +: 8];
    token_out <= cnt == 4'h7;
    if (go_in)
      cnt <= 4'h0;
    else if (!cnt[3])
      cnt <= cnt + 4'h1;
  end
endmodule
`default_nettype wire

// ==== verif/usfe_monitor.sv ====
// Purpose: assertions on the event pins and read port
// Assumes: mask half shadowed from bus writes to the event word
// Notes:   pins are registers only, so the shadow mask suffices
`default_nettype none
module usfe_monitor (
  input wire logic        clock_in,
  input wire logic        reset_in,
  input wire logic [7:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        write_in,
  input wire logic        read_in,
  input wire logic [31:0] rdata_out,
  input wire logic        status_token_in,
  input wire logic        status_done_in,
  input wire logic        ctrl_done_in,
  input wire logic        sof_token_in,
  input wire logic        zero_len_rx_in,
  input wire logic        zero_len_status_rd_in,
  input wire logic [7:0]  event_pins_out,
  input wire logic        irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] msk;
  wire  [7:0] mnx = (write_in && addr_in == 8'h08) ? wdata_in[15:8] : msk;
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // next mask is used so a write in the pulse cycle is judged right
  always @(posedge clock_in or posedge reset_in)
    if (reset_in)
      msk <= 8'h00;
    else
      msk <= mnx;
  chk_pin_mask: assert property ((event_pins_out & msk) == 8'h00)
    else $error("masked pin");
  chk_irq_any: assert property (irq_out == |event_pins_out)
    else $error("irq bad");
  chk_stok_pin: assert property (status_token_in && !mnx[1] |=> event_pins_out[1])
    else $error("stok pin");
  chk_sdone_pin: assert property (status_done_in && !mnx[2] |=> event_pins_out[2])
    else $error("sdone pin");
  chk_zero_pin: assert property (zero_len_rx_in && !zero_len_status_rd_in && !mnx[3]
    |=> event_pins_out[3])
    else $error("zero pin");
  chk_sof_pin: assert property (sof_token_in && !mnx[4] |=> event_pins_out[4])
    else $error("sof pin");
  chk_ctrl_pin: assert property (ctrl_done_in && !mnx[5] |=> event_pins_out[5])
    else $error("ctrl pin");
  chk_zero_held: assert property (zero_len_rx_in && zero_len_status_rd_in
    && !event_pins_out[3] |=> !event_pins_out[3])
    else $error("zero set");
  chk_rd_idle: assert property (!read_in |=> rdata_out == 32'h0)
    else $error("rdata idle");
endmodule
bind usfe_top usfe_monitor mon (.*);
`default_nettype wire
